// >>> rtl/afh_pkg.sv
// Package for the adapter fault/halt state controller.
// Assumes one 40 MHz clock and an APB slave port with 32-bit data.
package afh_pkg;
    // Clock rate for any timing derivation
    localparam int CLK_HZ = 40_000_000;

    // APB register byte addresses
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CMD      = 8'h00; // primary_port_cmd_reg
    localparam logic [7:0]  ADDR_STAT     = 8'h04; // State and self-test status
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08; // Sticky event bits, read-only
    localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h0C; // Write one to clear
    localparam logic [7:0]  ADDR_IRQ_EN   = 8'h10; // Interrupt enables

    // primary_port_cmd_reg fields
    localparam int CMD_LSB   = 0;
    localparam int CMD_W     = 4;
    localparam int RESET_BIT = 8;
    localparam int FUNC_LSB  = 12;
    localparam int FUNC_W    = 4;

    // Port command and ancillary codes
    localparam logic [3:0] CMD_NOP          = 4'h0;
    localparam logic [3:0] CMD_HALT         = 4'h1;
    localparam logic [3:0] CMD_ANCILLARY    = 4'h2;
    localparam logic [3:0] FUNC_START_MICRO = 4'h1;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PASS_BIT  = 4;
    localparam int STAT_FAIL_LSB  = 5;
    localparam int STAT_LCMD_LSB  = 8;
    localparam int STAT_CNT_LSB   = 16;

    // Interrupt event bits
    localparam int IRQ_PORT  = 0;
    localparam int IRQ_BUS   = 1;
    localparam int IRQ_NET   = 2;
    localparam int IRQ_BOTH  = 3;
    localparam int IRQ_READY = 4;
    localparam int IRQ_W     = 5;

    // Self-test failure classes
    localparam logic [1:0] FAIL_NONE  = 2'h0;
    localparam logic [1:0] FAIL_NET   = 2'h1;
    localparam logic [1:0] FAIL_DMA   = 2'h2;
    localparam logic [1:0] FAIL_OTHER = 2'h3;

    // Functional states handled here
    typedef enum logic [2:0] {
        ST_RESET,
        ST_READY,
        ST_PORT_HALT,
        ST_BUS_HALT,
        ST_NET_HALT,
        ST_BOTH_HALT
    } afh_state_t;
endpackage

// >>> rtl/afh_selftest.sv
// Self-test sequencer with a passed flag that survives soft resets.
// Assumes the test engine answers st_start with one st_done pulse.
`timescale 1ns/1ps
module afh_selftest
    import afh_pkg::*;
(
    // Clock and power-up reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Request from the state machine
    input  wire logic       run,
    // Test engine handshake
    output logic            st_start,
    input  wire logic       st_done,
    input  wire logic [1:0] st_fail,
    // Results
    output logic            passed,
    output logic            result_valid,
    output logic [1:0]      fail_code
);
    logic busy;          // Test in flight
    logic next_busy;
    logic next_start;
    logic next_passed;
    logic next_valid;
    logic [1:0] next_fail;

    // Start when run is high with no test busy or passed, latch the outcome
    always_comb begin
        next_busy   = busy;
        next_start  = 1'b0;
        next_passed = passed;
        next_valid  = 1'b0;
        next_fail   = fail_code;
        if (!busy && run && !passed && !st_start) begin
            next_busy  = 1'b1;
            next_start = 1'b1;
        end else if (busy && st_done) begin
            next_busy  = 1'b0;
            next_valid = 1'b1;
            next_fail  = st_fail;
            if (st_fail == FAIL_NONE) begin
                next_passed = 1'b1;
            end
        end
    end

    // Only srst, the power-up reset, clears passed
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy         <= 1'b0;
            st_start     <= 1'b0;
            passed       <= 1'b0;
            result_valid <= 1'b0;
            fail_code    <= FAIL_NONE;
        end else begin
            busy         <= next_busy;
            st_start     <= next_start;
            passed       <= next_passed;
            result_valid <= next_valid;
            fail_code    <= next_fail;
        end
    end

    AST_PASS_KEPT: assert property (@(posedge ref_clk) disable iff (srst)
        passed |=> passed)
        else $error("self-test passed flag dropped without power-up");
endmodule

// >>> rtl/afh_ctrl.sv
// Functional-state controller: halted states, reset and self-test exits.
// Assumes synchronous inputs on ref_clk; srst stands for power-up.
`timescale 1ns/1ps
module afh_ctrl
    import afh_pkg::*;
#(
    parameter int CNT_W = 8 // Accepted-command counter width
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Host bus and internal fault events
    input  wire logic        bus_init,
    input  wire logic        dma_fatal,
    input  wire logic        net_fatal,
    input  wire logic        other_fatal,
    // Self-test engine
    output logic             st_start,
    input  wire logic        st_done,
    input  wire logic [1:0]  st_fail,
    // Network side enables
    output logic             net_frame_en,
    output logic             loop_en,
    output logic             sysid_en,
    // Host facing status
    output logic             ucode_load_ok,
    output logic             cmd_accept_en,
    output logic [2:0]       state_code,
    output logic             irq
);
    generate
        if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
            $error("CNT_W must lie in 1..16");
        end
    endgenerate

    afh_state_t state;       // Current functional state
    afh_state_t next_state;
    logic [CMD_W-1:0] last_cmd;   // Last accepted port command
    logic [CMD_W-1:0] next_last_cmd;
    logic [CNT_W-1:0] cmd_count;  // Accepted commands since reset
    logic [CNT_W-1:0] next_cmd_count;
    logic [IRQ_W-1:0] irq_stat;   // Sticky events
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] irq_en;     // Event enables
    logic [IRQ_W-1:0] next_irq_en;
    logic [IRQ_W-1:0] events;     // State-entry events this cycle
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_net, next_loop, next_sysid, next_ucode, next_accept, next_irq;

    // Self-test results
    logic st_passed;
    logic st_valid;
    logic [1:0] st_code;

    // Decoded bus and command strobes
    logic acc;          // Access phase completing this edge
    logic cmd_write;    // Write to primary_port_cmd_reg
    logic reset_req;    // Any reset cause other than power-up
    logic cmd_ok;       // Current state accepts port commands
    logic halt_cmd;
    logic start_micro;

    // Field pick shared by command decodes
    function automatic logic [3:0] cmd_field(input logic [31:0] d);
        return d[CMD_LSB +: CMD_W];
    endfunction

    // Mapped-address check used by the pslverr error path only
    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_CMD || a == ADDR_STAT || a == ADDR_IRQ_STAT ||
               a == ADDR_IRQ_CLR || a == ADDR_IRQ_EN;
    endfunction

    afh_selftest u_selftest (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .run          (state == ST_RESET),
        .st_start     (st_start),
        .st_done      (st_done),
        .st_fail      (st_fail),
        .passed       (st_passed),
        .result_valid (st_valid),
        .fail_code    (st_code)
    );

    // Strobe decode; writes land on the edge that sees pready high
    always_comb begin
        acc         = psel && penable && pready;
        cmd_write   = acc && pwrite && paddr == ADDR_CMD;
        reset_req   = bus_init || (cmd_write && pwdata[RESET_BIT]);
        cmd_ok      = state == ST_READY || state == ST_PORT_HALT
                      || state == ST_NET_HALT;
        halt_cmd    = cmd_write && cmd_ok && cmd_field(pwdata) == CMD_HALT;
        start_micro = cmd_write && cmd_ok && cmd_field(pwdata) == CMD_ANCILLARY
                      && pwdata[FUNC_LSB +: FUNC_W] == FUNC_START_MICRO;
    end

    // Next functional state
    always_comb begin
        next_state = state;
        if (reset_req) begin
            next_state = ST_RESET;
        end else begin
            case (state)
                ST_RESET: begin
                    if (st_passed) begin
                        next_state = ST_READY;
                    end else if (st_valid) begin
                        case (st_code)
                            FAIL_NONE: next_state = ST_READY;
                            FAIL_NET:  next_state = ST_NET_HALT;
                            FAIL_DMA:  next_state = ST_BUS_HALT;
                            default:   next_state = ST_BOTH_HALT;
                        endcase
                    end
                end
                ST_READY: begin
                    if (other_fatal) begin
                        next_state = ST_BOTH_HALT;
                    end else if (dma_fatal) begin
                        next_state = ST_BUS_HALT;
                    end else if (net_fatal) begin
                        next_state = ST_NET_HALT;
                    end else if (halt_cmd) begin
                        next_state = ST_PORT_HALT;
                    end
                end
                ST_PORT_HALT: begin
                    if (other_fatal) begin
                        next_state = ST_BOTH_HALT;
                    end else if (dma_fatal) begin
                        next_state = ST_BUS_HALT;
                    end else if (start_micro) begin
                        next_state = ST_READY;
                    end
                end
                ST_BUS_HALT: begin
                    // Network failure on top of a bus halt leaves nothing alive
                    if (other_fatal || net_fatal) begin
                        next_state = ST_BOTH_HALT;
                    end
                end
                ST_NET_HALT: begin
                    if (other_fatal || dma_fatal) begin
                        next_state = ST_BOTH_HALT;
                    end
                end
                ST_BOTH_HALT: next_state = ST_BOTH_HALT;
                default:      next_state = ST_RESET;
            endcase
        end
    end

    // Command bookkeeping; halted-without-commands states drop writes
    always_comb begin
        next_last_cmd  = last_cmd;
        next_cmd_count = cmd_count;
        if (state == ST_RESET) begin
            next_last_cmd  = CMD_NOP;
            next_cmd_count = '0;
        end else if (cmd_write && cmd_ok && !reset_req) begin
            next_last_cmd  = cmd_field(pwdata);
            next_cmd_count = cmd_count + CNT_W'(1);
        end
    end

    // Events, interrupt registers; a set beats a clear in the same cycle
    always_comb begin
        events = '0;
        if (next_state != state) begin
            events[IRQ_PORT]  = next_state == ST_PORT_HALT;
            events[IRQ_BUS]   = next_state == ST_BUS_HALT;
            events[IRQ_NET]   = next_state == ST_NET_HALT;
            events[IRQ_BOTH]  = next_state == ST_BOTH_HALT;
            events[IRQ_READY] = next_state == ST_READY;
        end
        next_irq_stat = irq_stat;
        next_irq_en   = irq_en;
        if (acc && pwrite && paddr == ADDR_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
        end
        if (acc && pwrite && paddr == ADDR_IRQ_EN) begin
            next_irq_en = pwdata[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;
        next_irq      = |(next_irq_stat & next_irq_en);
    end

    // APB answer: one wait state, then pready with data
    always_comb begin
        next_pready  = psel && penable && !pready;
        next_pslverr = next_pready && !mapped(paddr);
        next_prdata  = '0;
        if (next_pready && !pwrite) begin
            case (paddr)
                ADDR_CMD: next_prdata[CMD_LSB +: CMD_W] = last_cmd;
                ADDR_STAT: begin
                    next_prdata[STAT_STATE_LSB +: 3] = state;
                    next_prdata[STAT_PASS_BIT]       = st_passed;
                    next_prdata[STAT_FAIL_LSB +: 2]  = st_code;
                    next_prdata[STAT_LCMD_LSB +: CMD_W] = last_cmd;
                    next_prdata[STAT_CNT_LSB +: CNT_W]  = cmd_count;
                end
                ADDR_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_stat;
                ADDR_IRQ_EN:   next_prdata[IRQ_W-1:0] = irq_en;
                default:       next_prdata = '0; // Clear register and holes
            endcase
        end
    end

    // Output enables follow the state being entered
    always_comb begin
        next_net    = next_state == ST_READY;
        next_loop   = next_state == ST_READY || next_state == ST_BUS_HALT;
        next_sysid  = next_state == ST_READY || next_state == ST_BUS_HALT;
        next_ucode  = next_state == ST_PORT_HALT;
        next_accept = next_state == ST_READY || next_state == ST_PORT_HALT
                      || next_state == ST_NET_HALT;
    end

    // All state registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state         <= ST_RESET;
            last_cmd      <= CMD_NOP;
            cmd_count     <= '0;
            irq_stat      <= '0;
            irq_en        <= '0;
            prdata        <= '0;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            net_frame_en  <= 1'b0;
            loop_en       <= 1'b0;
            sysid_en      <= 1'b0;
            ucode_load_ok <= 1'b0;
            cmd_accept_en <= 1'b0;
            state_code    <= '0;
            irq           <= 1'b0;
        end else begin
            state         <= next_state;
            last_cmd      <= next_last_cmd;
            cmd_count     <= next_cmd_count;
            irq_stat      <= next_irq_stat;
            irq_en        <= next_irq_en;
            prdata        <= next_prdata;
            pready        <= next_pready;
            pslverr       <= next_pslverr;
            net_frame_en  <= next_net;
            loop_en       <= next_loop;
            sysid_en      <= next_sysid;
            ucode_load_ok <= next_ucode;
            cmd_accept_en <= next_accept;
            state_code    <= next_state;
            irq           <= next_irq;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_HALT_ENTRY: assert property (
        state == ST_READY && halt_cmd && !reset_req && !dma_fatal && !net_fatal
        && !other_fatal |=> state == ST_PORT_HALT ##0 ucode_load_ok)
        else $error("halt command did not reach port halted");
    AST_PORT_QUIET: assert property (
        state == ST_PORT_HALT |-> !net_frame_en && !loop_en && !sysid_en)
        else $error("network active while port halted");
    AST_PORT_STAY: assert property (
        state == ST_PORT_HALT && !reset_req && !start_micro && !dma_fatal
        && !other_fatal |=> state == ST_PORT_HALT)
        else $error("port halted left without a valid exit");
    AST_DMA_FATAL: assert property (
        state == ST_READY && dma_fatal && !other_fatal && !reset_req
        |=> state == ST_BUS_HALT ##0 irq_stat[IRQ_BUS])
        else $error("DMA fatal error not taken");
    AST_BUS_ALIVE: assert property (
        state == ST_BUS_HALT |-> loop_en && sysid_en && !net_frame_en)
        else $error("loop or ID lost in host-bus halted");
    AST_BUS_IGNORE: assert property (
        state == ST_BUS_HALT && cmd_write && !reset_req
        |=> $stable(last_cmd) && $stable(cmd_count) && state == $past(next_state))
        else $error("command honoured in host-bus halted");
    AST_NET_FATAL: assert property (
        state == ST_READY && net_fatal && !dma_fatal && !other_fatal && !reset_req
        |=> state == ST_NET_HALT)
        else $error("network fatal error not taken");
    AST_NET_CMD: assert property (
        state == ST_NET_HALT && cmd_write && !reset_req
        |=> cmd_count == $past(cmd_count) + CNT_W'(1))
        else $error("command dropped in network-side halted");
    AST_BOTH_STAY: assert property (
        state == ST_BOTH_HALT && !reset_req |=> state == ST_BOTH_HALT)
        else $error("both halted left without init or reset");
    AST_RESET_WINS: assert property (
        reset_req |=> state == ST_RESET ##1 cmd_count == '0)
        else $error("reset cause did not reach reset state");
    AST_SKIP_TEST: assert property (
        state == ST_RESET && st_passed && !reset_req |=> state == ST_READY)
        else $error("passed self-test not skipped");
    AST_FAIL_DMA: assert property (
        state == ST_RESET && !st_passed && st_valid && st_code == FAIL_DMA
        && !reset_req |=> state == ST_BUS_HALT)
        else $error("DMA self-test failure misrouted");
    AST_NO_RETEST: assert property (
        st_passed |-> !st_start)
        else $error("self-test rerun after pass");
    AST_ESCALATE: assert property (
        state == ST_NET_HALT && dma_fatal && !reset_req |=> state == ST_BOTH_HALT)
        else $error("bus fatal in network-side halted not escalated");
endmodule

// >>> tb/afh_engine_model.sv
// Self-test engine model on the far side of st_start/st_done.
// Assumes the bench sets delay once and the result code before each power-up.
`timescale 1ns/1ps
module afh_engine_model (
    // Clock and power-up reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Handshake with the controller
    input  wire logic       st_start,
    output logic            st_done,
    output logic [1:0]      st_fail,
    // Scenario knobs and start counter
    input  wire logic [3:0] delay,
    input  wire logic [1:0] code,
    output logic [7:0]      starts
);
    logic [3:0] cnt; // Cycles left until the answer

    initial begin
        st_done = 1'b0;
        st_fail = 2'h0;
        starts  = 8'h00;
        cnt     = 4'h0;
    end

    // One done pulse per start; fail lines toggle while meaningless
    always @(posedge ref_clk) begin
        st_done <= 1'b0;
        st_fail <= ~st_fail; // Never looks like a held result
        if (srst) begin
            starts <= 8'h00;
            cnt    <= 4'h0;
        end else if (st_start) begin
            starts <= starts + 8'h01;
            cnt    <= (delay == 4'h0) ? 4'h1 : delay;
        end else if (cnt == 4'h1) begin
            st_done <= 1'b1;
            st_fail <= code;
            cnt     <= 4'h0;
        end else if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// >>> tb/tb_afh_ctrl.sv
// Bench for the fault/halt controller: APB host, fault events, test engine.
// Assumes the engine model above and registered APB answers.
`timescale 1ns/1ps
module tb_afh_ctrl;
    import afh_pkg::*;
    // Design connections
    logic        ref_clk, srst, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, bus_init, dma_fatal, net_fatal, other_fatal;
    logic        st_start, st_done, net_frame_en, loop_en, sysid_en;
    logic        ucode_load_ok, cmd_accept_en, irq;
    logic [1:0]  st_fail, eng_code;
    logic [2:0]  state_code;
    logic [3:0]  eng_delay;
    logic [7:0]  starts;
    // Model state and bookkeeping
    int          fails, n_compared, exp_st, cyc, c;
    logic [31:0] exp_irq, irq_en_v, rd, s0;
    logic        er;
    int          fail_map[4] = '{1, 4, 3, 5}; // Result code to state

    afh_ctrl #(.CNT_W(8)) DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_init(bus_init),
        .dma_fatal(dma_fatal), .net_fatal(net_fatal), .other_fatal(other_fatal),
        .st_start(st_start), .st_done(st_done), .st_fail(st_fail),
        .net_frame_en(net_frame_en), .loop_en(loop_en), .sysid_en(sysid_en),
        .ucode_load_ok(ucode_load_ok), .cmd_accept_en(cmd_accept_en),
        .state_code(state_code), .irq(irq));
    afh_engine_model ENG (.ref_clk(ref_clk), .srst(srst), .st_start(st_start),
        .st_done(st_done), .st_fail(st_fail), .delay(eng_delay), .code(eng_code),
        .starts(starts));

    // Clock at 40 MHz
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; pready is checked settled, then taken at the next edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            #1;
            ok = (pready === 1'b1);
            rd = prdata;
            er = pslverr;
            @(posedge ref_clk);
            n++;
        end while (!ok && n < 50);
        if (!ok) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Model update: new state sets its sticky event bit
    task automatic go(input int st);
        int b;
        b = (st == 1) ? IRQ_READY : st - 2;
        exp_st = st;
        if (st != 0) exp_irq[b] = 1'b1;
    endtask

    // Fault events for one cycle: {other, net, dma, init}
    task automatic ev(input logic [3:0] m);
        @(posedge ref_clk);
        {other_fatal, net_fatal, dma_fatal, bus_init} <= m;
        @(posedge ref_clk);
        {other_fatal, net_fatal, dma_fatal, bus_init} <= 4'h0;
    endtask

    // Wait a bounded time for the model state, then compare state code, enables and irq
    task automatic chk();
        int n;
        n = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        while (state_code !== exp_st[2:0] && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp(state_code, exp_st);
        cmp(net_frame_en, exp_st == 1);
        cmp(loop_en, exp_st == 1 || exp_st == 3);
        cmp(sysid_en, exp_st == 1 || exp_st == 3);
        cmp(ucode_load_ok, exp_st == 2);
        cmp(cmd_accept_en, exp_st == 1 || exp_st == 2 || exp_st == 4);
        cmp(irq, |(exp_irq & irq_en_v));
    endtask

    task automatic power_up(input logic [1:0] code);
        eng_code <= code;
        srst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        exp_irq = 32'h0;
        irq_en_v = 32'h0;
        go(fail_map[code]);
        chk();
    endtask

    initial begin
        void'($urandom(32'h8021));
        {psel, penable, pwrite, bus_init, dma_fatal, net_fatal, other_fatal} = 7'h00;
        {paddr, pwdata, fails, n_compared, cyc} = '0;
        eng_code = FAIL_NONE;
        eng_delay = 4'($urandom_range(1, 9));
        srst = 1'b1;
        exp_irq = 32'h0;
        irq_en_v = 32'h0;
        power_up(FAIL_NONE);
        cmp(starts, 1);
        irq_en_v = {27'h0, 5'($urandom)};
        apb(1'b1, ADDR_IRQ_EN, irq_en_v);
        apb(1'b1, ADDR_CMD, {28'h0, CMD_HALT}); // Halt from ready
        go(2);
        chk();
        apb(1'b1, ADDR_CMD, {16'h0, FUNC_START_MICRO, 8'h0, CMD_ANCILLARY});
        go(1);
        chk();
        ev(4'b0010);
        go(3);
        chk();
        apb(1'b1, ADDR_CMD, {28'h0, CMD_HALT});
        chk();
        apb(1'b1, ADDR_CMD, 32'h1 << RESET_BIT);
        go(1);
        chk();
        cmp(starts, 1);
        apb(1'b1, ADDR_CMD, {28'h0, CMD_HALT});
        ev(4'b0010);
        go(3);
        chk();
        ev(4'b0001);
        go(1);
        chk();
        ev(4'b0100);
        go(4);
        chk();
        apb(1'b1, ADDR_CMD, {28'h0, CMD_HALT});
        chk();
        apb(1'b0, ADDR_CMD, 32'h0);
        cmp(rd[3:0], CMD_HALT);
        ev(4'b0010);
        go(5);
        chk();
        apb(1'b1, ADDR_CMD, {16'h0, FUNC_START_MICRO, 8'h0, CMD_ANCILLARY});
        chk();
        ev(4'b1001);
        go(1);
        chk();
        ev(4'b1000);
        go(5);
        chk();
        apb(1'b0, ADDR_STAT, 32'h0);
        s0 = rd;
        cmp(s0[2:0], 5);
        cmp(s0[STAT_PASS_BIT], 1);
        apb(1'b1, ADDR_CMD, 32'h1 << RESET_BIT);
        go(1);
        chk();
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        cmp(rd, exp_irq);
        apb(1'b1, ADDR_IRQ_CLR, 32'h1F);
        exp_irq = 32'h0;
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        cmp(rd, 0);
        cmp(irq, 0);
        apb(1'b0, 8'h20, 32'h0);
        cmp(rd, 32'h0);
        cmp(er, 32'h1);
        for (c = 1; c < 4; c++) begin
            power_up(c[1:0]);
        end
        end_sim();
    end
endmodule
